// ===== verilog/rrw_pkg.sv
// result register window: shared constants and types
// assumes: byte-wide register addresses from the serial front end
package rrw_pkg;

    // ----------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS      = 8'h1D; // first byte of the coherent block read
    localparam logic [7:0] ADDR_CONTENT     = 8'h1E; // ram_content_kind
    localparam logic [7:0] ADDR_SEQ_ID      = 8'h1F; // update_sequence_id
    localparam logic [7:0] ADDR_ANSWER_CNT  = 8'h20; // answer_counter
    localparam logic [7:0] ADDR_QUALITY     = 8'h21; // measurement_quality
    localparam logic [7:0] ADDR_RANGE_LOW   = 8'h22; // range_mm_low
    localparam logic [7:0] ADDR_RANGE_HIGH  = 8'h23; // range_mm_high
    localparam logic [7:0] ADDR_TS_BYTE0    = 8'h24; // timestamp_byte0
    localparam logic [7:0] ADDR_BLOCK_LAST  = 8'h27; // last byte of the coherent block read

    // ----------------------------------------------------------
    // reset values
    // ----------------------------------------------------------
    localparam logic [7:0] RST_REG          = 8'h00; // every register resets to zero

    // ----------------------------------------------------------
    // content codes
    // ----------------------------------------------------------
    localparam logic [7:0] CODE_CALIB       = 8'h0A;
    localparam logic [7:0] CODE_SERIAL      = 8'h47;
    localparam logic [7:0] CODE_RESULTS     = 8'h55;
    localparam logic [7:0] CODE_HIST_FIRST  = 8'h80;
    localparam logic [7:0] CODE_HIST_LAST   = 8'h93;
    localparam logic [2:0] HIST_CONV_MAX    = 3'h4; // five converters, 0..4

    // ----------------------------------------------------------
    // quality field layout and codes
    // ----------------------------------------------------------
    localparam int         QUAL_STAT_MSB    = 7;
    localparam int         QUAL_STAT_LSB    = 6;
    localparam int         QUAL_REL_MSB     = 5;
    localparam int         QUAL_REL_LSB     = 0;
    localparam logic [1:0] STAT_NOT_INTR    = 2'h0; // immediate mode off: undisturbed
    localparam logic [1:0] STAT_GPIO_DELAY  = 2'h2; // immediate mode off: gpio delayed
    localparam logic [5:0] REL_NONE         = 6'h00;
    localparam logic [5:0] REL_SHORT_UNCAL  = 6'h01;
    localparam logic [5:0] REL_SHORT_CAL    = 6'h0A;
    localparam logic [5:0] REL_LONG_MIN     = 6'h02; // long result forced off the 0 and 1 codes
    localparam logic [5:0] REL_LONG_ALT     = 6'h0B; // long result forced off the 10 code

    // ----------------------------------------------------------
    // timestamp timing
    // ----------------------------------------------------------
    localparam int         SYS_CLK_KHZ      = 25000; // system clock, 40 ns
    localparam int         TS_OSC_KHZ       = 4700;  // timestamp tick, about 0.213 us
    localparam logic [7:0] TS_STEP          = 8'(TS_OSC_KHZ / 100);  // phase added per cycle
    localparam logic [7:0] TS_MODULUS       = 8'(SYS_CLK_KHZ / 100); // phase per tick

    // ----------------------------------------------------------
    // types
    // ----------------------------------------------------------
    typedef enum logic [1:0] {
        RRW_MAP_CALIB,
        RRW_MAP_SERIAL,
        RRW_MAP_HIST
    } rrw_map_sel_t;

    typedef enum logic [1:0] {
        RRW_REL_NONE,
        RRW_REL_SHORT_UNCAL,
        RRW_REL_SHORT_CAL,
        RRW_REL_LONG
    } rrw_rel_kind_t;

endpackage : rrw_pkg

// ===== verilog/rrw_timestamp.sv
// free-running 32-bit timestamp at the oscillator rate
// assumes: osc_run_in synchronous to clk_sys_in
`timescale 1ns/1ps
module rrw_timestamp (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        osc_run_in,  // oscillator running
    output logic      [31:0] ts_out,      // timestamp count
    output logic             valid_out    // count is meaningful
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    logic [7:0]  phase;       // fractional phase accumulator
    logic [7:0]  next_phase;
    logic [31:0] next_ts;
    logic        next_valid;
    logic [8:0]  sum;         // phase plus step, one bit of headroom

    // phase accumulator ticks 47 times per 250 system cycles
    always_comb begin
        sum        = {1'b0, phase} + {1'b0, rrw_pkg::TS_STEP};
        next_phase = phase;
        next_ts    = ts_out;
        next_valid = osc_run_in;
        if (osc_run_in) begin
            if (sum >= {1'b0, rrw_pkg::TS_MODULUS}) begin
                next_phase = 8'(sum - {1'b0, rrw_pkg::TS_MODULUS});
                next_ts    = ts_out + 32'h0000_0001; // wraps to zero
            end else begin
                next_phase = sum[7:0];
            end
        end
    end

    // register stage
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase     <= 8'h00;
            ts_out    <= 32'h0000_0000;
            valid_out <= 1'b0;
        end else begin
            phase     <= next_phase;
            ts_out    <= next_ts;
            valid_out <= next_valid;
        end
    end

endmodule : rrw_timestamp

// ===== verilog/rrw_hold.sv
// one-deep parking slot for a result that arrives during a block read
// assumes: load and clear are one-cycle pulses; load wins over clear
`timescale 1ns/1ps
module rrw_hold (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        load_in,   // park a result
    input  wire logic [24:0] data_in,   // {unique, quality, range}
    input  wire logic        clear_in,  // parked result consumed
    output logic             pend_out,  // a result is parked
    output logic      [24:0] data_out   // parked result
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    logic        next_pend;
    logic [24:0] next_data;

    // newest result overwrites; a unique mark is never dropped
    always_comb begin
        next_pend = pend_out;
        next_data = data_out;
        if (load_in) begin
            next_pend = 1'b1;
            next_data = data_in;
            next_data[24] = data_in[24] | (pend_out & data_out[24]);
        end else if (clear_in) begin
            next_pend = 1'b0;
        end
    end

    // register stage
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_out <= 1'b0;
            data_out <= 25'h000_0000;
        end else begin
            pend_out <= next_pend;
            data_out <= next_data;
        end
    end

endmodule : rrw_hold

// ===== verilog/rrw_result_window.sv
// result and bookkeeping registers of the ranging sensor
// assumes: serial front end gives one-cycle read and write strobes
// assumes: ranging_engine pulses are one cycle and synchronous
//
// Notes on behaviour
// - content code names what shared ram holds
// - histogram code is 80h plus converter*4 plus quarter
// - sequence id changes on every map update with a valid code
// - result registers readable only under results code
// - answer counter increments per unique answer
// - immediate mode: status is the capture outcome
// - normal mode: status 0 or 2 gpio delay
// - reliability sits in bits 5:0, 0..63
// - reliability 0 none, 1 uncal, 10 cal
// - range low byte at 22h, high at 23h
// - timestamp counts up and wraps to zero
// - tick is one 4.7 MHz period; byte at 24h
// - timestamp lsb set means valid, clear invalid
`timescale 1ns/1ps
module rrw_result_window (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // register port from the serial front end
    input  wire logic [7:0]  reg_addr_in,       // register address
    input  wire logic        reg_rd_in,         // read strobe
    input  wire logic        reg_wr_in,         // write strobe
    input  wire logic [7:0]  reg_wdata_in,      // write data
    input  wire logic        xfer_end_in,       // bus stop, ends a block read
    output logic      [7:0]  reg_rdata_out,     // read data
    output logic             reg_rvalid_out,    // read data valid pulse
    // map updates from ranging_engine
    input  wire logic        map_upd_in,        // non-result map loaded
    input  wire logic [1:0]  map_sel_in,        // rrw_map_sel_t
    input  wire logic [2:0]  hist_conv_in,      // time_converter_0..4
    input  wire logic [1:0]  hist_quarter_in,   // 64-bin group
    // result updates from ranging_engine
    input  wire logic        res_upd_in,        // result loaded
    input  wire logic        res_unique_in,     // result is a new answer
    input  wire logic        imm_irq_in,        // immediate interrupt setting
    input  wire logic [1:0]  capture_outcome_in,// outcome, immediate mode
    input  wire logic        gpio_delay_in,     // delayed by gpio, normal mode
    input  wire logic [1:0]  rel_kind_in,       // rrw_rel_kind_t
    input  wire logic [5:0]  rel_long_in,       // long-range reliability
    input  wire logic [15:0] range_mm_in,       // peak distance, mm
    input  wire logic        osc_run_in,        // internal oscillator running
    output logic             block_busy_out     // coherent block read open
);

    // ----------------------------------------------------------
    // types and state
    // ----------------------------------------------------------
    typedef enum logic {
        RRW_IDLE,
        RRW_BLOCK
    } rrw_blk_state_t;

    rrw_blk_state_t state;         // block read tracker
    rrw_blk_state_t next_state;
    logic [7:0]  content;          // ram_content_kind
    logic [7:0]  seq_id;           // update_sequence_id
    logic [7:0]  answer_cnt;       // answer_counter
    logic [7:0]  quality;          // measurement_quality
    logic [15:0] range_mm;         // range_mm_high, range_mm_low
    logic [7:0]  ts_byte;          // timestamp_byte0
    logic [7:0]  next_content;
    logic [7:0]  next_seq_id;
    logic [7:0]  next_answer_cnt;
    logic [7:0]  next_quality;
    logic [15:0] next_range_mm;
    logic [7:0]  next_ts_byte;
    logic [7:0]  next_rdata;
    logic        next_rvalid;

    logic [31:0] ts_count;         // timestamp count
    logic        ts_valid;         // timestamp meaningful
    logic        hold_pend;        // result parked during block
    logic [24:0] hold_data;        // parked {unique, quality, range}
    logic [24:0] live_res;         // incoming {unique, quality, range}
    logic [1:0]  stat_bits;        // status field of incoming result
    logic [5:0]  rel_bits;         // reliability of incoming result
    logic        block_open;       // block read in progress
    logic        take_live;        // apply incoming result now
    logic        take_hold;        // apply parked result now
    logic [24:0] apply_res;        // result being applied
    logic [7:0]  hist_code;        // histogram content code
    logic        map_ok;           // map update carries a valid code
    logic [7:0]  map_code;         // code of a non-result map update
    logic        wr_seen;          // write strobe, dropped on purpose

    // ----------------------------------------------------------
    // submodules
    // ----------------------------------------------------------
    rrw_timestamp u_timestamp (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .osc_run_in (osc_run_in),
        .ts_out     (ts_count),
        .valid_out  (ts_valid)
    );

    rrw_hold u_hold (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .load_in    (res_upd_in & block_open), // park while host reads
        .data_in    (live_res),
        .clear_in   (take_hold),
        .pend_out   (hold_pend),
        .data_out   (hold_data)
    );

    // ----------------------------------------------------------
    // incoming result encoding
    // ----------------------------------------------------------

    // status and reliability of the result ranging_engine offers
    always_comb begin
        if (imm_irq_in) begin
            stat_bits = capture_outcome_in;
        end else begin
            stat_bits = gpio_delay_in ? rrw_pkg::STAT_GPIO_DELAY
                                      : rrw_pkg::STAT_NOT_INTR;
        end
        case (rrw_pkg::rrw_rel_kind_t'(rel_kind_in))
            rrw_pkg::RRW_REL_NONE:        rel_bits = rrw_pkg::REL_NONE;
            rrw_pkg::RRW_REL_SHORT_UNCAL: rel_bits = rrw_pkg::REL_SHORT_UNCAL;
            rrw_pkg::RRW_REL_SHORT_CAL:   rel_bits = rrw_pkg::REL_SHORT_CAL;
            rrw_pkg::RRW_REL_LONG: begin
                // long result steers clear of the codes owned by other kinds
                if (rel_long_in == rrw_pkg::REL_SHORT_CAL) begin
                    rel_bits = rrw_pkg::REL_LONG_ALT;
                end else if (rel_long_in < rrw_pkg::REL_LONG_MIN) begin
                    rel_bits = rrw_pkg::REL_LONG_MIN;
                end else begin
                    rel_bits = rel_long_in;                      // 63 best
                end
            end
            default:                      rel_bits = rrw_pkg::REL_NONE;
        endcase
        live_res = {res_unique_in, stat_bits, rel_bits, range_mm_in};
    end

    // content code of a non-result map update
    always_comb begin
        hist_code = rrw_pkg::CODE_HIST_FIRST
                  + {3'h0, hist_conv_in, hist_quarter_in};
        map_ok    = 1'b1;
        case (rrw_pkg::rrw_map_sel_t'(map_sel_in))
            rrw_pkg::RRW_MAP_CALIB:  map_code = rrw_pkg::CODE_CALIB;
            rrw_pkg::RRW_MAP_SERIAL: map_code = rrw_pkg::CODE_SERIAL;
            rrw_pkg::RRW_MAP_HIST: begin
                map_code = hist_code;
                map_ok   = (hist_conv_in <= rrw_pkg::HIST_CONV_MAX);
            end
            default: begin
                map_code = content;
                map_ok   = 1'b0;                                 // unknown selector dropped
            end
        endcase
    end

    // ----------------------------------------------------------
    // register update and read path
    // ----------------------------------------------------------
    assign block_open     = (state == RRW_BLOCK);
    assign take_live      = res_upd_in & ~block_open;
    assign take_hold      = hold_pend & ~block_open;
    // a parked unique mark survives a live result in the same cycle
    assign apply_res      = take_live ? {live_res[24] | (take_hold & hold_data[24]), live_res[23:0]}
                                      : hold_data;
    assign block_busy_out = block_open;
    assign wr_seen        = reg_wr_in & (reg_wdata_in != reg_wdata_in); // never acts

    // next values of every register and of the tracker
    always_comb begin
        next_state      = state;
        next_content    = content;
        next_seq_id     = seq_id;
        next_answer_cnt = answer_cnt;
        next_quality    = quality;
        next_range_mm   = range_mm;
        next_ts_byte    = ts_byte;
        next_rdata      = reg_rdata_out;
        next_rvalid     = 1'b0;

        // results are applied only outside a block read
        if (take_live || take_hold) begin
            next_content  = rrw_pkg::CODE_RESULTS;
            next_seq_id   = seq_id + 8'h01;
            next_quality  = apply_res[23:16];
            next_range_mm = apply_res[15:0];
            if (apply_res[24]) begin
                next_answer_cnt = answer_cnt + 8'h01;
            end
        end else if (map_upd_in && map_ok) begin
            next_content = map_code;
            next_seq_id  = seq_id + 8'h01;
        end

        // timestamp byte follows the count outside a block read
        if (!block_open) begin
            next_ts_byte = {ts_count[7:1], ts_valid};
        end

        // block read tracker
        case (state)
            RRW_IDLE: begin
                if (reg_rd_in && reg_addr_in == rrw_pkg::ADDR_STATUS) begin
                    next_state = RRW_BLOCK;
                end
            end
            RRW_BLOCK: begin
                if (xfer_end_in ||
                    (reg_rd_in && reg_addr_in == rrw_pkg::ADDR_BLOCK_LAST)) begin
                    next_state = RRW_IDLE;
                end
            end
            default: next_state = RRW_IDLE;
        endcase

        // read mux; result registers only under the results code
        if (reg_rd_in) begin
            next_rvalid = 1'b1;
            next_rdata  = rrw_pkg::RST_REG;                      // unmapped reads zero
            case (reg_addr_in)
                rrw_pkg::ADDR_CONTENT: next_rdata = content;
                rrw_pkg::ADDR_SEQ_ID:  next_rdata = seq_id;
                default: begin
                    if (content == rrw_pkg::CODE_RESULTS) begin
                        case (reg_addr_in)
                            rrw_pkg::ADDR_ANSWER_CNT: next_rdata = answer_cnt;
                            rrw_pkg::ADDR_QUALITY:    next_rdata = quality;
                            rrw_pkg::ADDR_RANGE_LOW:  next_rdata = range_mm[7:0];
                            rrw_pkg::ADDR_RANGE_HIGH: next_rdata = range_mm[15:8];
                            rrw_pkg::ADDR_TS_BYTE0:   next_rdata = ts_byte;
                            default:                  next_rdata = rrw_pkg::RST_REG;
                        endcase
                    end
                end
            endcase
        end

        // writes land nowhere: no register takes reg_wdata_in
        if (wr_seen) begin
            next_seq_id = seq_id;
        end
    end

    // register stage
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state          <= RRW_IDLE;
            content        <= rrw_pkg::RST_REG;
            seq_id         <= rrw_pkg::RST_REG;
            answer_cnt     <= rrw_pkg::RST_REG;
            quality        <= rrw_pkg::RST_REG;
            range_mm       <= 16'h0000;
            ts_byte        <= rrw_pkg::RST_REG;
            reg_rdata_out  <= rrw_pkg::RST_REG;
            reg_rvalid_out <= 1'b0;
        end else begin
            state          <= next_state;
            content        <= next_content;
            seq_id         <= next_seq_id;
            answer_cnt     <= next_answer_cnt;
            quality        <= next_quality;
            range_mm       <= next_range_mm;
            ts_byte        <= next_ts_byte;
            reg_rdata_out  <= next_rdata;
            reg_rvalid_out <= next_rvalid;
        end
    end

endmodule : rrw_result_window

// ===== verif/rrw_props.sv
// checker: port timing of the result register window
// assumes: bound onto rrw_result_window, one clock domain
`timescale 1ns/1ps
module rrw_props (
    input wire logic       clk_sys_in,
    input wire logic       rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_rd_in,
    input wire logic       xfer_end_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_rvalid_out,
    input wire logic       map_upd_in,
    input wire logic [1:0] map_sel_in,
    input wire logic       res_upd_in,
    input wire logic       osc_run_in,
    input wire logic       block_busy_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic res_shown; // results code on show
    // follows which kind of map was loaded last
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) res_shown <= 1'h0;
        else if (res_upd_in) res_shown <= 1'h1;
        else if (map_upd_in && map_sel_in != 2'h3) res_shown <= 1'h0;
    end
    sequence s_close;
        xfer_end_in || (reg_rd_in && reg_addr_in == 8'h27);
    endsequence
    chk_read_answer: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
    chk_valid_pulse: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray read valid");
    chk_result_gate: assert property (reg_rd_in && reg_addr_in inside {[8'h20:8'h24]} && !res_shown
        && !block_busy_out |=> reg_rdata_out == 8'h00) else $error("result byte shown without results");
    chk_unmapped_zero: assert property (reg_rd_in && (reg_addr_in < 8'h1E || reg_addr_in > 8'h24)
        |=> reg_rdata_out == 8'h00) else $error("unmapped byte not zero");
    chk_block_open: assert property (reg_rd_in && reg_addr_in == 8'h1D && !block_busy_out
        |=> block_busy_out) else $error("block read not opened");
    chk_block_close: assert property (block_busy_out ##0 s_close |=> !block_busy_out)
        else $error("block read not closed");
    chk_block_hold: assert property (block_busy_out && !xfer_end_in && !(reg_rd_in && reg_addr_in == 8'h27)
        |=> block_busy_out) else $error("block read dropped early");
    // run flag takes three edges to reach the read data: valid flop, byte flop, read flop
    chk_ts_valid: assert property (reg_rd_in && reg_addr_in == 8'h24 && res_shown && !block_busy_out
        && !$past(block_busy_out) |=> reg_rdata_out[0] == $past(osc_run_in, 3))
        else $error("timestamp valid bit wrong");
endmodule : rrw_props

// ===== verif/rrw_host_model.sv
// host model: a run of register reads, one strobe per cycle
// assumes: each read answered one cycle after its strobe
`timescale 1ns/1ps
module rrw_host_model (
    input  wire logic       clk_sys_in,
    input  wire logic       start_in,         // begin a run
    input  wire logic [7:0] first_in,         // first address
    input  wire logic [7:0] last_in,          // last address
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    output logic            rd_out   = 1'h0,
    output logic      [7:0] addr_out = 8'h00,
    output logic            busy_out = 1'h0,
    output logic      [7:0] got_out [0:15]    // bytes by low address nibble
);
    logic [7:0] addr_q; // address of the read in flight
    logic       rd_q;   // strobe of the cycle before
    // strobe sequencer and answer capture
    always @(posedge clk_sys_in) begin
        addr_q <= addr_out;
        rd_q   <= rd_out;
        if (rvalid_in) got_out[addr_q[3:0]] <= rdata_in;
        if (start_in && !busy_out) begin
            {rd_out, addr_out, busy_out} <= {1'h1, first_in, 1'h1};
        end else if (rd_out && addr_out != last_in) addr_out <= addr_out + 8'h01;
        else if (rd_out) {rd_out, addr_out} <= {1'h0, ~addr_out}; // released bus shows no stale address
        else if (!rd_q && !rvalid_in) busy_out <= 1'h0;
    end
endmodule : rrw_host_model

// ===== verif/rrw_testbench.sv
// testbench: reads through the host model, engine updates from the bench
// assumes: rrw_result_window and rrw_host_model compiled before
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
    logic        clk_sys_in = 1'h0, rst_n_in = 1'h0, reg_wr_in = 1'h0, xfer_end_in = 1'h0, start = 1'h0;
    logic        map_upd_in = 1'h0, res_upd_in = 1'h0, res_unique_in = 1'h0, imm_irq_in = 1'h0;
    logic        gpio_delay_in = 1'h0, osc_run_in = 1'h0, reg_rd_in, reg_rvalid_out, block_busy_out, hbusy;
    logic [1:0]  map_sel_in = 2'h0, hist_quarter_in = 2'h0, capture_outcome_in = 2'h0, rel_kind_in = 2'h0;
    logic [2:0]  hist_conv_in = 3'h0;
    logic [5:0]  rel_long_in = 6'h00;
    logic [15:0] range_mm_in = 16'h0000;
    logic [7:0]  reg_wdata_in = 8'h00, first = 8'h00, last = 8'h00, seq = 8'h00, cnt = 8'h00, j, t0;
    logic [7:0]  reg_addr_in, reg_rdata_out, got [0:15];
    int          err_total = 0, check_count = 0;
    rrw_result_window uut (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_rd_in, .reg_wr_in, .reg_wdata_in,
        .xfer_end_in, .reg_rdata_out, .reg_rvalid_out, .map_upd_in, .map_sel_in, .hist_conv_in,
        .hist_quarter_in, .res_upd_in, .res_unique_in, .imm_irq_in, .capture_outcome_in, .gpio_delay_in,
        .rel_kind_in, .rel_long_in, .range_mm_in, .osc_run_in, .block_busy_out);
    rrw_host_model host (.clk_sys_in, .start_in(start), .first_in(first), .last_in(last), .rdata_in(reg_rdata_out),
        .rvalid_in(reg_rvalid_out), .rd_out(reg_rd_in), .addr_out(reg_addr_in), .busy_out(hbusy), .got_out(got));
    task automatic tick();
        @(posedge clk_sys_in);
        #1;
    endtask : tick
    // a run of reads, waited out under a bound
    task automatic run(input logic [7:0] f, input logic [7:0] l);
        {first, last, start} = {f, l, 1'h1};
        tick();
        start = 1'h0;
        for (int n = 0; n < 40 && hbusy === 1'h1; n++) tick();
    endtask : run
    task automatic rd1(input logic [7:0] a, input logic [7:0] e);
        run(a, a);
        `CHK(got[a[3:0]], e)
    endtask : rd1
    // one result from the engine, expected counts follow
    task automatic res(input logic im, input logic [1:0] oc, input logic gp, input logic [1:0] rk,
                       input logic [15:0] rg, input logic un);
        {imm_irq_in, capture_outcome_in, gpio_delay_in, rel_kind_in} = {im, oc, gp, rk};
        {range_mm_in, res_unique_in, res_upd_in} = {rg, un, 1'h1};
        tick();
        res_upd_in = 1'h0;
        seq = seq + 8'h01;
        cnt = cnt + {7'h00, un};
    endtask : res
    task automatic map(input logic [1:0] s, input logic [2:0] c, input logic [1:0] q);
        {map_sel_in, hist_conv_in, hist_quarter_in, map_upd_in} = {s, c, q, 1'h1};
        tick();
        map_upd_in = 1'h0;
        seq = seq + 8'h01;
    endtask : map
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // watchdog against a hung handshake
    initial begin
        #(40 * 6000);
        err_total++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk_sys_in);
        #1;
        rst_n_in = 1'h1;
        for (j = 8'h1E; j <= 8'h24; j++) rd1(j, 8'h00);
        osc_run_in = 1'h1;
        map(2'h0, 3'h0, 2'h0);
        rd1(8'h1E, 8'h0A);
        map(2'h1, 3'h0, 2'h0);
        rd1(8'h1E, 8'h47);
        for (j = 8'h00; j < 8'h14; j++) begin
            map(2'h2, j[4:2], j[1:0]);
            rd1(8'h1E, 8'h80 + j);
        end
        rd1(8'h1F, seq);
        rel_long_in = 6'h3F;
        for (j = 8'h00; j < 8'h04; j++) begin
            res(1'h1, j[1:0], 1'h0, 2'h3, 16'h1234 + {8'h00, j}, 1'h1);
            rd1(8'h21, {j[1:0], 6'h3F});
        end
        rd1(8'h1E, 8'h55);
        rd1(8'h22, 8'h37);
        rd1(8'h23, 8'h12);
        rel_long_in = 6'h0A;
        for (j = 8'h00; j < 8'h04; j++) begin
            res(1'h0, 2'h3, j[0], j[1:0], 16'h0102, j[0]);
            rd1(8'h21, {j[0], 3'h0, j[1], 1'h0, j[1], j[0]});
            rd1(8'h20, cnt);
            rd1(8'h1F, seq);
        end
        {reg_wdata_in, reg_wr_in} = {8'hA5, 1'h1};
        tick();
        reg_wr_in = 1'h0;
        rd1(8'h1F, seq);
        rd1(8'h22, 8'h02);
        fork
            run(8'h1D, 8'h27);
            begin
                repeat (3) tick(); // result lands once the block read is open
                res(1'h0, 2'h0, 1'h0, 2'h0, 16'h0A0B, 1'h1);
            end
        join
        `CHK({got[3], got[2]}, 16'h0102)
        `CHK(got[0], cnt - 8'h01)
        rd1(8'h22, 8'h0B);
        rd1(8'h20, cnt);
        run(8'h1D, 8'h20);
        `CHK(block_busy_out, 1'h1)
        xfer_end_in = 1'h1;
        tick();
        xfer_end_in = 1'h0;
        `CHK(block_busy_out, 1'h0)
        run(8'h24, 8'h24);
        t0 = got[4];
        `CHK(t0[0], 1'h1)
        repeat (100) tick();
        run(8'h24, 8'h24);
        `CHK((got[4] - t0) inside {[8'h10:8'h16]}, 1'h1)
        osc_run_in = 1'h0;
        repeat (2) tick();
        run(8'h24, 8'h24);
        `CHK(got[4][0], 1'h0)
        map(2'h0, 3'h0, 2'h0);
        rd1(8'h22, 8'h00);
        map(2'h3, 3'h0, 2'h0); // unknown selector, dropped
        map(2'h2, 3'h5, 2'h0); // converter out of range, dropped
        seq = seq - 8'h02;
        rd1(8'h1E, 8'h0A);
        rd1(8'h1F, seq);
        end_sim();
    end
endmodule : testbench
bind rrw_result_window rrw_props u_props (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_rd_in, .xfer_end_in,
    .reg_rdata_out, .reg_rvalid_out, .map_upd_in, .map_sel_in, .res_upd_in, .osc_run_in, .block_busy_out);
